// ==== dclc_pkg.sv ====
/*
 * Package for the divider channel leaf controller: register offsets, field
 * positions, reset values, mode encodings, the repeat count width and slip states.
 * Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package dclc_pkg;

    // Register byte offsets
    localparam logic [3:0]  DCLC_CTRL_OFS     = 4'h0;
    localparam logic [3:0]  DCLC_SLIP_OFS     = 4'h4;
    localparam logic [3:0]  DCLC_STAT_OFS     = 4'h8;

    // Control register field positions
    localparam int          DCLC_EN_BIT       = 0;
    localparam int          DCLC_SLIP_ACC_BIT = 1;
    localparam int          DCLC_RPH_ACC_BIT  = 2;
    localparam int          DCLC_MSLIP_BIT    = 3;
    localparam int          DCLC_BUF_DYN_BIT  = 4;
    localparam int          DCLC_START_LSB    = 8;
    localparam int          DCLC_MUTE_LSB     = 12;

    // Control and slip register reset values
    localparam logic [31:0] DCLC_CTRL_RST     = 32'h0000_0000;
    localparam logic [11:0] DCLC_SLIP_RST     = 12'h001;

    // Startup modes
    localparam logic [1:0]  DCLC_START_ASYNC  = 2'h0;
    localparam logic [1:0]  DCLC_START_DYN    = 2'h3;

    // Idle output level encodings
    localparam logic [1:0]  DCLC_MUTE_FLOAT   = 2'h0;
    localparam logic [1:0]  DCLC_MUTE_ZERO    = 2'h2;

    // Width of the repeat count
    localparam int          DCLC_CNT_W        = 12;

    // Slip sequencer states
    typedef enum logic [1:0] {
        DCLC_SL_IDLE  = 2'b00,
        DCLC_SL_PAUSE = 2'b01,
        DCLC_SL_GAP   = 2'b10
    } dclc_slip_st_t;

endpackage : dclc_pkg

// ==== dclc_slip_seq.sv ====
/*
 * Repeat-slip sequencer: turns one slip request into a train of one-cycle
 * clock pauses, each pause moving the divider phase by one clock period.
 * Assumes requests are single-cycle pulses synchronous to clk.
 */
`timescale 1ns/1ps
module dclc_slip_seq
    import dclc_pkg::*;
#(
    parameter int CNT_W = DCLC_CNT_W
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire logic             repeat_en,
    input  wire logic [CNT_W-1:0] repeat_cnt,
    output logic                  gate_ff,
    output logic                  busy_ff,
    output logic                  done_ff
);

    // Elaboration-time check: counter widths outside this range are not served
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt_w
        $error("dclc_slip_seq: CNT_W out of range");
    end

    dclc_slip_st_t      st_ff;
    dclc_slip_st_t      nxt_st;
    logic [CNT_W-1:0]   target_ff;
    logic [CNT_W-1:0]   done_cnt_ff;
    logic [CNT_W-1:0]   nxt_done_cnt;

    // Next state: pause one cycle, then one gap cycle before the next pause
    always_comb begin
        nxt_st       = st_ff;
        nxt_done_cnt = done_cnt_ff;
        unique case (st_ff)
            DCLC_SL_IDLE: begin
                if (start) begin
                    nxt_st       = DCLC_SL_PAUSE;
                    nxt_done_cnt = '0;
                end
            end
            DCLC_SL_PAUSE: begin
                nxt_done_cnt = done_cnt_ff + 1'b1;          // [RL20]
                nxt_st       = DCLC_SL_GAP;
            end
            DCLC_SL_GAP: begin
                // Only finished once every programmed slip has happened
                if (done_cnt_ff >= target_ff) begin          // [RL20]
                    nxt_st = DCLC_SL_IDLE;
                end else begin
                    nxt_st = DCLC_SL_PAUSE;
                end
            end
            default: nxt_st = DCLC_SL_IDLE;
        endcase
    end

    // State and counters
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff       <= DCLC_SL_IDLE;
            done_cnt_ff <= '0;
        end else begin
            st_ff       <= nxt_st;
            done_cnt_ff <= nxt_done_cnt;
        end
    end

    // Latch the slip count at start; count of one when repeat is off
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            target_ff <= CNT_W'(1);
        end else if (st_ff == DCLC_SL_IDLE && start) begin
            target_ff <= repeat_en ? repeat_cnt : CNT_W'(1);  // [RL12] [RL13]
        end
    end

    // Registered outputs: gate pauses the divider clock for one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            gate_ff <= (nxt_st == DCLC_SL_PAUSE);            // [RL19]
            busy_ff <= (nxt_st != DCLC_SL_IDLE);
            done_ff <= (st_ff == DCLC_SL_GAP) && (nxt_st == DCLC_SL_IDLE);
        end
    end

    // Each pause lasts exactly one cycle
    pause_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        gate_ff |=> !gate_ff) else $error("slip pause longer than one cycle"); // [RL19]

endmodule : dclc_slip_seq

// ==== dclc_leaf.sv ====
/*
 * Divider channel leaf controller for one output channel: reacts to
 * broadcast slip, sync and pulse-chain events, drives divider power, divider
 * rephase, clock gating, output buffer enable and idle mute.
 * Assumes broadcast events are one-cycle pulses synchronous to clk and that
 * software reaches the controls over Avalon-MM with waitrequest.
 */
// The implementer's own choices: the Avalon-MM register port and the register offsets.
// Functional notes
// RL1 - Slip accept enables port and input slips
// RL2 - Repeat-slip auto-launches after sync or chain start
// RL3 - Rephase accept enables divider reset on sync
// RL4 - Rephase accept toggles safely at any time
// RL5 - Startup 00: free-running, rephased if accepted
// RL6 - Startup 11: power around pulse chains
// RL7 - Software: dynamic mode only above ratio 31
// RL8 - Buffer-follows 0: buffer follows channel enable
// RL9 - Buffer-follows 1: buffer gated with divider
// RL10 - Mute 10: force zero when idle
// RL11 - Mute 00: leave output floating when idle
// RL12 - Repeat enable selects programmed count or one
// RL13 - Repeat: each slip repeated count times
// RL14 - Software: no zero count with repeat
// RL15 - Done indication when phase operations complete
// RL16 - Software follows recommended channel configurations
// RL17 - Channel enable 0 keeps channel disabled
// RL18 - Sync aligns divider to reference timer
// RL19 - Each slip pauses divider clock one cycle
// RL20 - Sequencer reports finish after all slips
`timescale 1ns/1ps
module dclc_leaf
    import dclc_pkg::*;
#(
    parameter int CNT_W = DCLC_CNT_W
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Avalon-MM slave
    input  wire logic [3:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    // Broadcast events
    input  wire logic             slip_port_req,
    input  wire logic             slip_gpin_req,
    input  wire logic             sync_req,
    input  wire logic             timer_tick,
    input  wire logic             chain_pre,
    input  wire logic             chain_start,
    input  wire logic             chain_end,
    // To divider, retimer and buffer
    output logic                  div_power_ff,
    output logic                  div_rephase_ff,
    output logic                  div_gate_ff,
    output logic                  buf_enable_ff,
    output logic                  mute_zero_ff,
    output logic                  mute_float_ff,
    output logic                  phase_done_ff
);

    // Elaboration-time check: the repeat field is fixed at the package width
    if (CNT_W != DCLC_CNT_W) begin : g_bad_cnt_w
        $error("dclc_leaf: CNT_W must match the repeat field");
    end

    logic [31:0]      ctrl_ff;
    logic [CNT_W-1:0] slip_cnt_ff;
    logic             ack_ff;
    logic             sync_pend_ff;
    logic             chain_ff;
    logic             auto_slip_ff;
    logic             seq_gate;
    logic             seq_busy;
    logic             seq_done;
    logic             slip_go;

    wire logic       ch_en      = ctrl_ff[DCLC_EN_BIT];
    wire logic       slip_acc   = ctrl_ff[DCLC_SLIP_ACC_BIT];
    wire logic       rph_acc    = ctrl_ff[DCLC_RPH_ACC_BIT];
    wire logic       mslip_en   = ctrl_ff[DCLC_MSLIP_BIT];
    wire logic       buf_dyn    = ctrl_ff[DCLC_BUF_DYN_BIT];
    wire logic [1:0] start_mode = ctrl_ff[DCLC_START_LSB +: 2];
    wire logic [1:0] mute_mode  = ctrl_ff[DCLC_MUTE_LSB +: 2];
    wire logic       dyn_mode   = (start_mode == DCLC_START_DYN);

    wire logic       bus_req    = (avs_read || avs_write) && !ack_ff;

    // One wait state: every access is answered on the second edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    // Waitrequest has a flop of its own so the output comes off a register;
    // it always equals the inverse of ack_ff
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !bus_req;
        end
    end

    // Register writes take effect on the answering edge, byte lanes honoured
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_ff     <= DCLC_CTRL_RST;
            slip_cnt_ff <= DCLC_SLIP_RST;
        end else if (avs_write && ack_ff) begin
            if (avs_address == DCLC_CTRL_OFS) begin
                for (int b = 0; b < 4; b++) begin
                    if (avs_byteenable[b]) begin
                        ctrl_ff[8*b +: 8] <= avs_writedata[8*b +: 8];
                    end
                end
            end else if (avs_address == DCLC_SLIP_OFS) begin
                if (avs_byteenable[0]) begin
                    slip_cnt_ff[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    slip_cnt_ff[CNT_W-1:8] <= avs_writedata[CNT_W-1:8];
                end
            end
        end
    end

    // Read data registered; unmapped offsets read as zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && bus_req) begin
            unique case (avs_address)
                DCLC_CTRL_OFS: avs_readdata <= ctrl_ff;
                DCLC_SLIP_OFS: avs_readdata <= {20'h00000, slip_cnt_ff};
                DCLC_STAT_OFS: avs_readdata <= {27'h0000000, phase_done_ff,
                                                seq_busy, chain_ff,
                                                buf_enable_ff, div_power_ff};
                default:       avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // A sync waits for the next reference timer tick so channels share origin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_pend_ff <= 1'b0;
        end else if (!ch_en) begin
            sync_pend_ff <= 1'b0;                            // [RL17]
        end else if (sync_req) begin
            sync_pend_ff <= 1'b1;                            // [RL18]
        end else if (timer_tick) begin
            sync_pend_ff <= 1'b0;
        end
    end

    // Chain window tracking for dynamic mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chain_ff <= 1'b0;
        end else if (!ch_en || !dyn_mode) begin
            chain_ff <= 1'b0;
        end else if (chain_pre) begin
            chain_ff <= 1'b1;                                // [RL6]
        end else if (chain_end) begin
            chain_ff <= 1'b0;                                // [RL6]
        end
    end

    // Rephase pulse; accept bit only gates the trigger, so toggling it never
    // touches divider state mid-count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_rephase_ff <= 1'b0;
        end else begin
            div_rephase_ff <= ch_en && (                     // [RL17]
                (rph_acc && sync_pend_ff && timer_tick)      // [RL3] [RL4] [RL5] [RL18]
                || (dyn_mode && chain_start));               // [RL6]
        end
    end

    // Auto repeat-slip one cycle after a recognised sync or chain start
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            auto_slip_ff <= 1'b0;
        end else begin
            auto_slip_ff <= mslip_en && ch_en &&
                ((rph_acc && sync_pend_ff && timer_tick)
                 || (dyn_mode && chain_start));              // [RL2]
        end
    end

    // Slip trigger; requests while a train runs are ignored
    assign slip_go = ch_en && !seq_busy &&
                     ((slip_acc && (slip_port_req || slip_gpin_req))  // [RL1]
                      || auto_slip_ff);                                // [RL2]

    dclc_slip_seq #(
        .CNT_W      (CNT_W)
    ) u_slip (
        .clk        (clk),
        .rst_n      (rst_n),
        .start      (slip_go),
        .repeat_en  (mslip_en),                              // [RL12]
        .repeat_cnt (slip_cnt_ff),                           // [RL13]
        .gate_ff    (seq_gate),
        .busy_ff    (seq_busy),
        .done_ff    (seq_done)
    );

    // Clock gate follows the sequencer pause
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_gate_ff <= 1'b0;
        end else begin
            div_gate_ff <= seq_gate;                         // [RL19]
        end
    end

    // Done flag: low while a slip, a pending sync or an auto slip is in flight;
    // train end sets it and wins over a clear in the same cycle, and a sync
    // that resolves without slips lets it rise again so it cannot stick low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_done_ff <= 1'b1;
        end else if (seq_done) begin
            phase_done_ff <= 1'b1;                           // [RL15] [RL20]
        end else if (slip_go || sync_pend_ff || auto_slip_ff || seq_busy) begin
            phase_done_ff <= 1'b0;
        end else begin
            phase_done_ff <= 1'b1;                           // [RL15]
        end
    end

    // Divider power: free-running in async mode, chain window in dynamic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_power_ff <= 1'b0;
        end else begin
            div_power_ff <= ch_en && (dyn_mode ? (chain_ff || chain_pre)   // [RL6]
                                               : 1'b1);                    // [RL5] [RL17]
        end
    end

    // Buffer enable: from channel enable, or gated with divider when buf_dyn is set in dynamic mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            buf_enable_ff <= 1'b0;
        end else if (buf_dyn && dyn_mode) begin
            buf_enable_ff <= ch_en && (chain_ff || chain_pre);             // [RL9]
        end else begin
            buf_enable_ff <= ch_en;                                        // [RL8]
        end
    end

    // Idle mute: registered copy of the combinational gate the output stage uses
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mute_zero_ff  <= 1'b0;
            mute_float_ff <= 1'b0;
        end else begin
            mute_zero_ff  <= ch_en && dyn_mode && !chain_ff &&
                             (mute_mode == DCLC_MUTE_ZERO);                // [RL10]
            mute_float_ff <= ch_en && dyn_mode && !chain_ff &&
                             (mute_mode == DCLC_MUTE_FLOAT);               // [RL11]
        end
    end

    // Disabled channel shows no power and no buffer
    chan_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ch_en |=> !div_power_ff && !buf_enable_ff)
        else $error("disabled channel powered"); // [RL17]

    // Accepted slip from the port starts the divider clock gate two cycles later
    slip_accept_a: assert property (@(posedge clk) disable iff (!rst_n)
        slip_go |=> ##1 div_gate_ff)
        else $error("slip did not pause the clock"); // [RL1]

    // Ignored slip when accept bit clear
    slip_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!slip_acc && !auto_slip_ff) |-> !slip_go)
        else $error("slip taken without accept"); // [RL1]

    // Sync on tick rephases when accepted
    sync_rephase_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ch_en && rph_acc && sync_pend_ff && timer_tick) |=> div_rephase_ff)
        else $error("accepted sync did not rephase"); // [RL3]

    // Auto repeat-slip follows a recognised sync
    auto_slip_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ch_en && mslip_en && rph_acc && sync_pend_ff && timer_tick) |=> auto_slip_ff)
        else $error("repeat slip not launched"); // [RL2]

    // Buffer follows enable when not dynamic
    buf_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        !buf_dyn |=> buf_enable_ff == $past(ch_en))
        else $error("buffer not following enable"); // [RL8]

    // Idle zero mute in dynamic mode outside chains
    mute_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ch_en && dyn_mode && !chain_ff && mute_mode == DCLC_MUTE_ZERO) |=> mute_zero_ff)
        else $error("idle output not forced low"); // [RL10]

    // Done is low while a train runs
    done_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        (seq_busy && !seq_done) |=> !phase_done_ff)
        else $error("done shown during slips"); // [RL15]

endmodule : dclc_leaf

// ==== dclc_evsrc.sv ====
/*
 * Broadcast event source model: free-running reference timer ticks and
 * pulse-chain power-up, start and end events for the channel controller.
 * Assumes one clock; outputs change by non-blocking assignment after edges.
 */
`timescale 1ns/1ps
module dclc_evsrc #(
    parameter int TICK_P = 16
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      tick_ff,
    output logic      pre_ff,
    output logic      start_ff,
    output logic      end_ff
);
    int tcnt_ff;

    // Reference timer runs free, one-cycle tick per period
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tcnt_ff <= 0;
            tick_ff <= 1'b0;
        end else begin
            tcnt_ff <= (tcnt_ff == TICK_P - 1) ? 0 : tcnt_ff + 1;
            tick_ff <= (tcnt_ff == TICK_P - 1);
        end
    end

    // Chain events idle low until a chain is asked for
    initial begin
        pre_ff   = 1'b0;
        start_ff = 1'b0;
        end_ff   = 1'b0;
    end

    // Each chain event follows a timer tick by one cycle, one cycle wide
    task automatic at_tick(input int w);
        do @(posedge clk); while (tick_ff !== 1'b1);
        case (w)
            0: pre_ff <= 1'b1;
            1: start_ff <= 1'b1;
            default: end_ff <= 1'b1;
        endcase
        @(posedge clk);
        pre_ff   <= 1'b0;
        start_ff <= 1'b0;
        end_ff   <= 1'b0;
    endtask : at_tick

    // Power-up always precedes start, so the divider is awake in time
    task automatic chain_begin;
        at_tick(0);
        at_tick(1);
    endtask : chain_begin

    task automatic chain_finish;
        at_tick(2);
    endtask : chain_finish
endmodule : dclc_evsrc

// ==== testbench.sv ====
/*
 * Self-checking bench for the divider channel leaf controller: register
 * bus, slips, repeat slips, sync and pulse chains against integer models.
 * Assumes the event source model for ticks and chain events.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module testbench
    import dclc_pkg::*;
;
    localparam int TICK_P = 16;
    logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd, rnd;
    logic        slip_port_req, slip_gpin_req, sync_req;
    logic        timer_tick, chain_pre, chain_start, chain_end;
    logic        div_power_ff, div_rephase_ff, div_gate_ff, buf_enable_ff;
    logic        mute_zero_ff, mute_float_ff, phase_done_ff;
    int          n_fail, comparisons, cyc, n_gate, n_reph, g0, r0, cnt, en, bf, mu;

    dclc_leaf dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .slip_port_req(slip_port_req),
        .slip_gpin_req(slip_gpin_req), .sync_req(sync_req), .timer_tick(timer_tick),
        .chain_pre(chain_pre), .chain_start(chain_start), .chain_end(chain_end),
        .div_power_ff(div_power_ff), .div_rephase_ff(div_rephase_ff),
        .div_gate_ff(div_gate_ff), .buf_enable_ff(buf_enable_ff),
        .mute_zero_ff(mute_zero_ff), .mute_float_ff(mute_float_ff),
        .phase_done_ff(phase_done_ff));

    dclc_evsrc #(.TICK_P(TICK_P)) u_src (.clk(clk), .rst_n(rst_n),
        .tick_ff(timer_tick), .pre_ff(chain_pre), .start_ff(chain_start),
        .end_ff(chain_end));

    // Clock at 10 MHz
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Count gate and rephase pulses; each is one cycle wide
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (div_gate_ff === 1'b1) n_gate++;
        if (div_rephase_ff === 1'b1) n_reph++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function logic [31:0] cw(input int e, sa, ra, rp, b, st, m);
        return {18'h0, m[1:0], 2'h0, st[1:0], 3'h0, b[0], rp[0], ra[0], sa[0], e[0]};
    endfunction : cw

    // Bus cycle held until waitrequest is seen low; read data taken there
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do begin
            @(posedge clk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        `CHK("waitrequest", 0, avs_waitrequest);
    endtask : bus

    task ev(input int w);
        @(posedge clk);
        case (w)
            0: slip_port_req <= 1'b1;
            1: slip_gpin_req <= 1'b1;
            default: sync_req <= 1'b1;
        endcase
        @(posedge clk);
        slip_port_req <= 1'b0;
        slip_gpin_req <= 1'b0;
        sync_req      <= 1'b0;
    endtask : ev

    // Waits for the done flag with a bound, since slips take time
    task settle(input int m);
        int t;
        t = 0;
        repeat (m) @(posedge clk);
        while (phase_done_ff !== 1'b1 && t < 500) begin
            @(posedge clk);
            t++;
        end
        repeat (2) @(posedge clk);
        `CHK("phase_done", 1, phase_done_ff);
    endtask : settle

    // Model: accepted slip gives count pulses with repeat on, else one
    task slip_case(input int e, sa, rp, c, src);
        bus(1, DCLC_CTRL_OFS, cw(e, sa, 1, rp, 0, 0, 0));
        bus(1, DCLC_SLIP_OFS, 32'(c));
        g0 = n_gate;
        ev(src);
        settle(3);
        `CHK("gates", (e && sa) ? (rp ? c : 1) : 0, n_gate - g0);
        `CHK("power", e, div_power_ff);
        $display("slip test en %0d acc %0d rep %0d cnt %0d done", e, sa, rp, c);
    endtask : slip_case

    initial begin
        {avs_read, avs_write, slip_port_req, slip_gpin_req, sync_req} = '0;
        avs_address    = 4'h0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hf;
        {n_fail, comparisons, cyc, n_gate, n_reph} = '0;
        rnd   = 32'h206fce2c;
        rst_n = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Reset values, unmapped place and read-only status
        `CHK("done_rst", 1, phase_done_ff);
        bus(0, DCLC_CTRL_OFS, 0);
        `CHK("ctrl_rst", DCLC_CTRL_RST, rd);
        bus(0, DCLC_SLIP_OFS, 0);
        `CHK("slip_rst", {20'h0, DCLC_SLIP_RST}, rd);
        bus(1, DCLC_STAT_OFS, 32'hffffffff);
        bus(0, DCLC_STAT_OFS, 0);
        `CHK("stat_rst", 32'h10, rd);
        bus(0, 4'hc, 0);
        `CHK("unmapped", 0, rd);
        bus(1, DCLC_CTRL_OFS, cw(1, 1, 1, 1, 1, 0, 2));
        bus(0, DCLC_CTRL_OFS, 0);
        `CHK("ctrl_rb", cw(1, 1, 1, 1, 1, 0, 2), rd);
        $display("register test done");
        slip_case(1, 0, 0, 1, 0);
        slip_case(0, 1, 1, 4, 1);
        slip_case(1, 1, 0, 5, 1);
        // Random counts never zero while repeat is on
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            slip_case(1, 1, 1, (i == 0) ? 1 : int'(rnd[3:0]) + 2, i % 2);
        end
        // Rephase accept toggled in mid-train must not upset the slips
        bus(1, DCLC_SLIP_OFS, 32'h00c);
        g0 = n_gate;
        ev(0);
        bus(1, DCLC_CTRL_OFS, cw(1, 1, 0, 1, 0, 0, 0));
        bus(1, DCLC_CTRL_OFS, cw(1, 1, 1, 1, 0, 0, 0));
        `CHK("power_tog", 1, div_power_ff);
        settle(1);
        `CHK("gates_tog", 12, n_gate - g0);
        $display("toggle test done");
        // Sync with and without rephase accept and repeat
        for (int i = 0; i < 4; i++) begin
            bus(1, DCLC_CTRL_OFS, cw(1, 1, i % 2, i / 2, 0, 0, 0));
            bus(1, DCLC_SLIP_OFS, 32'h003);
            g0 = n_gate;
            r0 = n_reph;
            ev(2);
            settle(TICK_P + 4);
            `CHK("rephase", i % 2, n_reph - r0);
            `CHK("auto_gates", (i == 3) ? 3 : 0, n_gate - g0);
            $display("sync test %0d done", i);
        end
        // Dynamic startup with recommended chain setup
        // Divide ratio taken as above 31 for the dynamic channel
        for (int i = 0; i < 3; i++) begin
            en = (i < 2);
            bf = (i != 1);
            mu = (i == 1) ? 0 : 2;
            bus(1, DCLC_CTRL_OFS, cw(en, 1, 1, 0, bf, 3, mu));
            repeat (4) @(posedge clk);
            `CHK("pw_idle", 0, div_power_ff);
            `CHK("buf_idle", en && !bf, buf_enable_ff);
            `CHK("mz_idle", en && mu == 2, mute_zero_ff);
            `CHK("mf_idle", en && mu == 0, mute_float_ff);
            r0 = n_reph;
            u_src.chain_begin();
            repeat (4) @(posedge clk);
            `CHK("pw_chain", en, div_power_ff);
            `CHK("buf_chain", en, buf_enable_ff);
            `CHK("mz_chain", 0, mute_zero_ff);
            `CHK("reph_chain", en, n_reph - r0);
            u_src.chain_finish();
            repeat (4) @(posedge clk);
            `CHK("pw_end", 0, div_power_ff);
            `CHK("buf_end", en && !bf, buf_enable_ff);
            `CHK("mz_end", en && mu == 2, mute_zero_ff);
            `CHK("mf_end", en && mu == 0, mute_float_ff);
            $display("chain test %0d done", i);
        end
        final_report();
    end
endmodule : testbench
